// >>> lpm_ctrl.sv
// Low-power mode controller: idle, power down and emulation float
module lpm_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset pin and wake sources
  input wire logic rst_pin,
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  input wire logic irq_pending,
  // Processor side
  input wire logic xdata_cyc,
  output logic cpu_halt,
  output logic periph_run,
  output logic osc_en,
  output logic ram_block,
  output logic sys_reset,
  output logic cpu_resume,
  output logic [1:0] resume_src,
  // Strobe pins, sampled inputs and drive
  input wire logic ale_i,
  input wire logic program_store_strobe_i,
  output logic ale_o,
  output logic ale_oe,
  output logic program_store_strobe_o,
  output logic program_store_strobe_oe,
  // Port control
  output logic p0_float,
  output logic p2_addr,
  output logic ports_weak
);

  // ----------------------------------------
  // Reset qualifier and strobe timing
  // ----------------------------------------
  logic rst_hold;
  logic ale_run;
  logic pstb_run;
  lpm_pkg::lpm_ctrl_t ctrl_q, ctrl_d;

  lpm_rst_filter u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .rst_pin(rst_pin),
    .rst_hold(rst_hold)
  );

  lpm_strobe_gen u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .ext_prog(ctrl_q.ext_prog),
    .xdata_cyc(xdata_cyc),
    .ale(ale_run),
    .pstb(pstb_run)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  lpm_pkg::lpm_state_t st_q, st_d;
  logic rst_hold_q;
  logic strap_q, strap_d;
  logic emu_q, emu_d;
  logic [1:0] wake_q, wake_d;
  logic resume_q, resume_d;
  logic [1:0] rsrc_q, rsrc_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_stat;
  logic wake0;
  logic wake1;

  assign hit_ctrl = (paddr == lpm_pkg::OFS_CTRL);
  assign hit_stat = (paddr == lpm_pkg::OFS_STAT);
  assign wr_acc = psel && penable && pwrite && hit_ctrl;

  // Wake pins qualify only when enabled and level-sensitive
  assign wake0 = !ext_irq_zero_n && ctrl_q.irq0_en
                 && ctrl_q.irq0_lvl;
  assign wake1 = !ext_irq_one_n && ctrl_q.irq1_en
                 && ctrl_q.irq1_lvl;

  always_comb begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    strap_d = strap_q;
    emu_d = emu_q;
    wake_d = wake_q;
    resume_d = 1'b0;
    rsrc_d = rsrc_q;
    if (rst_hold) begin
      // Control registers reload, RAM is not touched
      ctrl_d = lpm_pkg::CTRL_RST;
      wake_d = 2'b00;
      emu_d = 1'b0;
      st_d = lpm_pkg::ST_RUN;
      if (!ale_i && program_store_strobe_i) begin
        strap_d = 1'b1;
      end
    end else if (rst_hold_q) begin
      // Release of reset: strap still low enters emulation float
      strap_d = 1'b0;
      if (strap_q && !ale_i) begin
        emu_d = 1'b1;
        st_d = lpm_pkg::ST_EMU;
      end
    end else begin
      case (st_q)
        lpm_pkg::ST_RUN: begin
          if (ctrl_q.pd_req) begin
            st_d = lpm_pkg::ST_PDOWN;
          end else if (ctrl_q.idle_req) begin
            st_d = lpm_pkg::ST_IDLE;
          end
        end
        lpm_pkg::ST_IDLE: begin
          if (rst_pin) begin
            st_d = lpm_pkg::ST_RST_EXIT;
          end else if (irq_pending) begin
            st_d = lpm_pkg::ST_RUN;
            ctrl_d.idle_req = 1'b0;
          end
        end
        lpm_pkg::ST_RST_EXIT: begin
          // Reset not held long enough: fall back to running
          if (!rst_pin) begin
            st_d = lpm_pkg::ST_RUN;
            ctrl_d.idle_req = 1'b0;
          end
        end
        lpm_pkg::ST_PDOWN: begin
          if (wake0 || wake1) begin
            st_d = lpm_pkg::ST_PD_WAKE;
            wake_d = {wake1, wake0};
          end
        end
        lpm_pkg::ST_PD_WAKE: begin
          // Exit completes once the waking pin is high again
          if ((!wake_q[0] || ext_irq_zero_n) &&
              (!wake_q[1] || ext_irq_one_n)) begin
            st_d = lpm_pkg::ST_RUN;
            ctrl_d.pd_req = 1'b0;
            resume_d = 1'b1;
            rsrc_d = wake_q;
          end
        end
        lpm_pkg::ST_EMU: begin
          st_d = lpm_pkg::ST_EMU;
        end
        default: begin
          st_d = lpm_pkg::ST_RUN;
        end
      endcase
      // Writes land in every state except power down and its wake exit
      if (wr_acc && st_q != lpm_pkg::ST_PDOWN &&
          st_q != lpm_pkg::ST_PD_WAKE) begin
        ctrl_d = lpm_pkg::lpm_ctrl_t'(pwdata[lpm_pkg::CTRL_W-1:0]);
      end
    end
  end

  // ----------------------------------------
  // APB read data, captured in the setup phase
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (psel && !penable) begin
      rdata_d = 32'h0000_0000;
      if (hit_ctrl) begin
        rdata_d[lpm_pkg::CTRL_W-1:0] = ctrl_q;
      end else if (hit_stat) begin
        rdata_d[lpm_pkg::STAT_MODE +: 3] = st_q;
        rdata_d[lpm_pkg::STAT_OSC] = osc_en;
        rdata_d[lpm_pkg::STAT_EMU] = emu_q;
        rdata_d[lpm_pkg::STAT_WK0] = wake_q[0];
        rdata_d[lpm_pkg::STAT_WK1] = wake_q[1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= lpm_pkg::ST_RUN;
      ctrl_q <= lpm_pkg::CTRL_RST;
      rst_hold_q <= 1'b0;
      strap_q <= 1'b0;
      emu_q <= 1'b0;
      wake_q <= 2'b00;
      resume_q <= 1'b0;
      rsrc_q <= 2'b00;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      rst_hold_q <= rst_hold;
      strap_q <= strap_d;
      emu_q <= emu_d;
      wake_q <= wake_d;
      resume_q <= resume_d;
      rsrc_q <= rsrc_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit_ctrl
                   && !(hit_stat && !pwrite);

  // ----------------------------------------
  // Processor and clock control
  // ----------------------------------------
  logic in_pd;
  assign in_pd = (st_q == lpm_pkg::ST_PDOWN) ||
                 (st_q == lpm_pkg::ST_PD_WAKE);

  assign cpu_halt = rst_hold || in_pd || emu_q ||
                    (st_q == lpm_pkg::ST_IDLE);
  assign periph_run = !in_pd;
  // Oscillator restarts on a qualifying low wake pin or a reset pin
  assign osc_en = (st_q != lpm_pkg::ST_PDOWN) || rst_pin;
  assign ram_block = rst_hold || in_pd || (st_q == lpm_pkg::ST_IDLE)
                     || (st_q == lpm_pkg::ST_RST_EXIT);
  assign sys_reset = rst_hold;
  assign cpu_resume = resume_q;
  assign resume_src = rsrc_q;

  // ----------------------------------------
  // Pin states per mode
  // ----------------------------------------
  lpm_pkg::lpm_pins_t pins;

  always_comb begin
    pins.ale_o = ale_run;
    pins.ale_oe = !rst_hold;
    pins.pstb_o = pstb_run;
    pins.pstb_oe = 1'b1;
    pins.p0_float = 1'b0;
    pins.p2_addr = ctrl_q.ext_prog;
    pins.ports_weak = 1'b0;
    if (emu_q) begin
      // Drivers off; weak pull-ups hold strobes and ports high
      pins.ale_o = 1'b1;
      pins.ale_oe = 1'b0;
      pins.pstb_o = 1'b1;
      pins.pstb_oe = 1'b0;
      pins.p0_float = 1'b1;
      pins.p2_addr = 1'b0;
      pins.ports_weak = 1'b1;
    end else if (in_pd) begin
      pins.ale_o = 1'b0;
      pins.pstb_o = 1'b0;
      pins.p0_float = ctrl_q.ext_prog;
      pins.p2_addr = 1'b0;
    end else if (st_q == lpm_pkg::ST_IDLE) begin
      pins.ale_o = 1'b1;
      pins.pstb_o = 1'b1;
      pins.p0_float = ctrl_q.ext_prog;
      pins.p2_addr = ctrl_q.ext_prog;
    end
  end

  assign ale_o = pins.ale_o;
  assign ale_oe = pins.ale_oe;
  assign program_store_strobe_o = pins.pstb_o;
  assign program_store_strobe_oe = pins.pstb_oe;
  assign p0_float = pins.p0_float;
  assign p2_addr = pins.p2_addr;
  assign ports_weak = pins.ports_weak;

endmodule

// >>> lpm_pkg.sv
// Shared constants and types for the low-power mode controller
package lpm_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;

  // Control register field positions
  localparam int CTRL_IDLE = 0;
  localparam int CTRL_PD = 1;
  localparam int CTRL_EXTP = 2;
  localparam int CTRL_EN0 = 3;
  localparam int CTRL_EN1 = 4;
  localparam int CTRL_LVL0 = 5;
  localparam int CTRL_LVL1 = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Status register field positions
  localparam int STAT_MODE = 0;
  localparam int STAT_OSC = 3;
  localparam int STAT_EMU = 4;
  localparam int STAT_WK0 = 5;
  localparam int STAT_WK1 = 6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int MACH_CLKS = 12;
  localparam int RST_MACH = 2;
  localparam int RST_CLKS = RST_MACH * MACH_CLKS;
  localparam logic [4:0] RST_CNT_MAX = 5'(RST_CLKS);
  localparam logic [3:0] PH_LAST = 4'(MACH_CLKS - 1);
  // Strobe phases inside one machine cycle
  localparam logic [3:0] PH_ALE_A = 4'h0;
  localparam logic [3:0] PH_ALE_B = 4'h6;
  localparam logic [3:0] PH_PS_A = 4'h3;
  localparam logic [3:0] PH_PS_B = 4'h9;
  localparam logic [3:0] PH_LEN_ALE = 4'h2;
  localparam logic [3:0] PH_LEN_PS = 4'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE, ST_RST_EXIT, ST_PDOWN, ST_PD_WAKE, ST_EMU
  } lpm_state_t;

  typedef struct packed {
    logic irq1_lvl;
    logic irq0_lvl;
    logic irq1_en;
    logic irq0_en;
    logic ext_prog;
    logic pd_req;
    logic idle_req;
  } lpm_ctrl_t;

  typedef struct packed {
    logic ale_o;
    logic ale_oe;
    logic pstb_o;
    logic pstb_oe;
    logic p0_float;
    logic p2_addr;
    logic ports_weak;
  } lpm_pins_t;

endpackage

// >>> lpm_rst_filter.sv
// Reset pin qualifier: recognises a reset held for two machine cycles
module lpm_rst_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reset pin level
  input wire logic rst_pin,
  // Recognised reset, high while the pin stays high
  output logic rst_hold
);

  logic [4:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (!rst_pin) begin
      cnt_d = 5'h00;
    end else if (cnt_q != lpm_pkg::RST_CNT_MAX) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign rst_hold = (cnt_q == lpm_pkg::RST_CNT_MAX);

endmodule

// >>> lpm_strobe_gen.sv
// Machine-cycle strobe generator for the address latch and program strobes
module lpm_strobe_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus activity
  input wire logic ext_prog,
  input wire logic xdata_cyc,
  // Free-running strobes
  output logic ale,
  output logic pstb
);

  logic [3:0] ph_q, ph_d;
  logic ale_q, ale_d;
  logic pstb_q, pstb_d;

  always_comb begin
    ph_d = (ph_q == lpm_pkg::PH_LAST) ? 4'h0 : ph_q + 4'h1;
    // Two latch pulses per machine cycle, second one skipped on xdata
    ale_d = (ph_d >= lpm_pkg::PH_ALE_A &&
             ph_d < lpm_pkg::PH_ALE_A + lpm_pkg::PH_LEN_ALE) ||
            (!xdata_cyc && ph_d >= lpm_pkg::PH_ALE_B &&
             ph_d < lpm_pkg::PH_ALE_B + lpm_pkg::PH_LEN_ALE);
    // Program strobe low twice per cycle for external code only, none during xdata cycles
    pstb_d = !(ext_prog && !xdata_cyc &&
               ((ph_d >= lpm_pkg::PH_PS_A &&
                 ph_d < lpm_pkg::PH_PS_A + lpm_pkg::PH_LEN_PS) ||
                (ph_d >= lpm_pkg::PH_PS_B &&
                 ph_d < lpm_pkg::PH_PS_B + lpm_pkg::PH_LEN_PS)));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= lpm_pkg::PH_LAST;
      ale_q <= 1'b0;
      pstb_q <= 1'b1;
    end else begin
      ph_q <= ph_d;
      ale_q <= ale_d;
      pstb_q <= pstb_d;
    end
  end

  assign ale = ale_q;
  assign pstb = pstb_q;

endmodule

// >>> lpm_ctrl_assertions.sv
// Port-level checks for the low-power mode controller
module lpm_ctrl_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Wake and reset inputs
  input wire logic rst_pin,
  input wire logic ext_irq_zero_n,
  input wire logic irq_pending,
  // Mode outputs
  input wire logic cpu_halt,
  input wire logic periph_run,
  input wire logic osc_en,
  input wire logic ram_block,
  input wire logic sys_reset,
  input wire logic cpu_resume,
  input wire logic [1:0] resume_src,
  // Pin drive
  input wire logic ale_o,
  input wire logic ale_oe,
  input wire logic program_store_strobe_o,
  input wire logic program_store_strobe_oe,
  input wire logic p0_float,
  input wire logic ports_weak
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic idle_now;
  assign idle_now = cpu_halt && periph_run && !ports_weak && !sys_reset;

  sequence s_resume_pulse;
    !cpu_halt && periph_run ##1 !cpu_resume;
  endsequence

  a_idle_strobes: assert property (
    idle_now && ale_oe |-> ale_o && program_store_strobe_o)
    else $error("idle strobes not high");
  a_pd_strobes: assert property (
    !periph_run && !osc_en |-> !ale_o && !program_store_strobe_o)
    else $error("power down strobes not low");
  a_pd_halts: assert property (!periph_run |-> cpu_halt)
    else $error("processor runs in power down");
  a_pd_osc_stop: assert property (
    $fell(periph_run) && !rst_pin |-> !osc_en)
    else $error("oscillator runs on power down entry");
  a_resume_pulse: assert property (cpu_resume |-> s_resume_pulse)
    else $error("resume pulse malformed");
  a_resume_pin: assert property (
    cpu_resume && resume_src[0] |-> $past(ext_irq_zero_n))
    else $error("wake finished with pin low");
  a_reset_qualify: assert property (
    $rose(sys_reset) |-> $past(rst_pin, 24))
    else $error("reset recognised too early");
  a_emu_float: assert property (
    ports_weak |-> p0_float && !ale_oe && !program_store_strobe_oe && osc_en)
    else $error("emulation float pins wrong");
  a_emu_hold: assert property (ports_weak && !sys_reset |=> ports_weak)
    else $error("emulation float left without reset");
  a_idle_ram: assert property (
    idle_now && rst_pin && !irq_pending |=> ram_block)
    else $error("ram not blocked on reset exit");
endmodule

// >>> lpm_far_side.sv
// Far-side model: reset circuit, wake pins and emulator strap
module lpm_far_side (
  // Clock
  input wire logic pclk,
  // Scenario commands
  input wire logic rst_req,
  input wire logic irq0_req,
  input wire logic irq1_req,
  input wire logic emu_req,
  // Block outputs
  input wire logic osc_en,
  input wire logic ale_o,
  input wire logic ale_oe,
  input wire logic program_store_strobe_o,
  input wire logic program_store_strobe_oe,
  // Pin levels
  output logic rst_pin,
  output logic ext_irq_zero_n,
  output logic ext_irq_one_n,
  output logic ale_i,
  output logic program_store_strobe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter int STAB_CLKS = 16;
  int stab_q = 0;
  logic irq0_low_q = 1'b0;

  // Wake pin stays low until the oscillator has settled
  always_ff @(posedge pclk) begin
    stab_q <= !osc_en ? 0 : (stab_q < STAB_CLKS ? stab_q + 1 : stab_q);
    irq0_low_q <= irq0_req || (irq0_low_q && stab_q < STAB_CLKS);
  end

  assign rst_pin = rst_req;
  assign ext_irq_zero_n = !irq0_low_q;
  assign ext_irq_one_n = !irq1_req;
  // Undriven strobes sit at their pull-up level; emu_req holds ALE low
  assign ale_i = emu_req ? 1'b0 : (ale_oe ? ale_o : 1'b1);
  assign program_store_strobe_i = program_store_strobe_oe ?
    program_store_strobe_o : 1'b1;
endmodule

// >>> lpm_ctrl_tb_top.sv
// Self-checking bench for the low-power mode controller
module lpm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic irq_pending = 1'b0, xdata_cyc = 1'b0;
  logic rst_req = 1'b0, irq0_req = 1'b0, irq1_req = 1'b0, emu_req = 1'b0;
  logic rst_pin, ext_irq_zero_n, ext_irq_one_n, ale_i, program_store_strobe_i;
  logic cpu_halt, periph_run, osc_en, ram_block, sys_reset, cpu_resume;
  logic [1:0] resume_src;
  logic ale_o, ale_oe, program_store_strobe_o, program_store_strobe_oe;
  logic p0_float, p2_addr, ports_weak;
  int fails = 0;
  int tests_run = 0;

  lpm_ctrl lpm_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rst_pin, .ext_irq_zero_n,
    .ext_irq_one_n, .irq_pending, .xdata_cyc, .cpu_halt, .periph_run, .osc_en,
    .ram_block, .sys_reset, .cpu_resume, .resume_src, .ale_i,
    .program_store_strobe_i, .ale_o, .ale_oe, .program_store_strobe_o,
    .program_store_strobe_oe, .p0_float, .p2_addr, .ports_weak);
  lpm_far_side lpm_far_side_inst (.pclk, .rst_req, .irq0_req, .irq1_req,
    .emu_req, .osc_en, .ale_o, .ale_oe, .program_store_strobe_o,
    .program_store_strobe_oe, .rst_pin, .ext_irq_zero_n, .ext_irq_one_n,
    .ale_i, .program_store_strobe_i);

  initial begin
    forever #4 pclk = ~pclk;
  end

  function automatic logic [7:0] st();
    return {cpu_halt, periph_run, osc_en, ram_block, sys_reset, ale_o,
      program_store_strobe_o, ports_weak};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Selects a watched output: 0 osc_en, 1 sys_reset, 2 cpu_resume
  function automatic logic pick(input int i);
    logic [2:0] s;
    s = {cpu_resume, sys_reset, osc_en};
    return s[i];
  endfunction

  task automatic wt(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(i) !== v && n < lim) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(pick(i)), 32'(v));
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Mode change from a write shows one edge after the write edge
    cyc(2);
  endtask

  task automatic t_regs;
    apb(1'b0, lpm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'(lpm_pkg::CTRL_RST));
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'hffff_ff7c);
    apb(1'b0, lpm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h7c);
    apb(1'b1, lpm_pkg::OFS_STAT, 32'hff);
    chk(32'(err), 32'h1);
    apb(1'b0, lpm_pkg::OFS_STAT, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'({err, rd[7:0]}), 32'h100);
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_strobe(input logic x, input logic [31:0] ea, input logic [31:0] ep);
    int na, np;
    logic pa, pp;
    na = 0;
    np = 0;
    xdata_cyc <= x;
    cyc(24);
    pa = ale_o;
    pp = program_store_strobe_o;
    repeat (120) begin
      @(posedge pclk);
      if (ale_o && !pa) na++;
      if (!program_store_strobe_o && pp) np++;
      pa = ale_o;
      pp = program_store_strobe_o;
    end
    chk(32'(na), ea);
    chk(32'(np), ep);
  endtask

  task automatic t_idle;
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h05);
    chk(32'(st()), 32'hf6);
    chk(32'({p0_float, p2_addr}), 32'h3);
    apb(1'b0, lpm_pkg::OFS_STAT, 32'h0);
    chk(rd, 32'h09);
    irq_pending <= 1'b1;
    @(posedge pclk);
    irq_pending <= 1'b0;
    @(posedge pclk);
    chk(32'(cpu_halt), 32'h0);
    apb(1'b0, lpm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h04);
  endtask

  task automatic t_pd_irq;
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h3e);
    chk(32'(st()), 32'h90);
    chk(32'({p0_float, p2_addr}), 32'h2);
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h0);
    irq1_req <= 1'b1;
    irq_pending <= 1'b1;
    cyc(20);
    chk(32'(st()), 32'h90);
    irq1_req <= 1'b0;
    irq_pending <= 1'b0;
    irq0_req <= 1'b1;
    wt(0, 1'b1, 40);
    irq0_req <= 1'b0;
    cyc(8);
    chk(32'(cpu_halt), 32'h1);
    wt(2, 1'b1, 100);
    chk(32'(resume_src), 32'h1);
    apb(1'b0, lpm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h3c);
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_reset_exit(input logic [31:0] c, input logic [7:0] e);
    apb(1'b1, lpm_pkg::OFS_CTRL, c);
    chk(32'(st()), 32'(e));
    rst_req <= 1'b1;
    cyc(3);
    chk(32'({cpu_halt, ram_block, osc_en}), c[1] ? 32'h7 : 32'h3);
    cyc(18);
    chk(32'(sys_reset), 32'h0);
    wt(1, 1'b1, 20);
    rst_req <= 1'b0;
    cyc(3);
    apb(1'b0, lpm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_emu;
    emu_req <= 1'b1;
    rst_req <= 1'b1;
    cyc(20);
    wt(1, 1'b1, 20);
    rst_req <= 1'b0;
    cyc(3);
    emu_req <= 1'b0;
    chk(32'({ports_weak, p0_float, ale_oe, program_store_strobe_oe, osc_en,
      cpu_halt}), 32'h33);
    cyc(40);
    chk(32'(ports_weak), 32'h1);
    rst_req <= 1'b1;
    cyc(20);
    wt(1, 1'b1, 20);
    rst_req <= 1'b0;
    cyc(3);
    chk(32'(ports_weak), 32'h0);
  endtask

  task automatic finish_test;
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(6);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_strobe(1'b0, 32'd20, 32'd0);
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h04);
    t_strobe(1'b0, 32'd20, 32'd20);
    t_strobe(1'b1, 32'd10, 32'd0);
    xdata_cyc <= 1'b0;
    apb(1'b1, lpm_pkg::OFS_CTRL, 32'h0);
    t_idle;
    t_pd_irq;
    t_reset_exit(32'h2b, 8'h90);
    t_reset_exit(32'h01, 8'hf6);
    t_emu;
    finish_test;
  end

  initial begin
    cyc(20000);
    fails++;
    finish_test;
  end
endmodule

bind lpm_ctrl lpm_ctrl_assertions lpm_ctrl_assertions_inst (.pclk, .presetn,
  .rst_pin, .ext_irq_zero_n, .irq_pending, .cpu_halt, .periph_run, .osc_en,
  .ram_block, .sys_reset, .cpu_resume, .resume_src, .ale_o, .ale_oe,
  .program_store_strobe_o, .program_store_strobe_oe, .p0_float, .ports_weak);
